// File: rtl/lhm_link_end.sv
/*
 * Link end: four 48-bit performance counters of one link layer with a
 * per-counter packet header match filter, reached in configuration space.
 * Assumes flit slot headers come from logic on the same clock and that
 * the configuration end holds each request until ack.
 */
`timescale 1ns/1ps
`default_nettype none

module lhm_link_end
#(
    parameter logic [4:0] LINK_DEV = lhm_pkg::CFG_DEV_LINK0
)
(
    // clock and reset
    input  wire logic                                     clock_in,
    input  wire logic                                     nrst_in,
    // configuration access
    lhm_cfg_if.link_end                                   cfg,
    // flit slot headers
    input  wire lhm_pkg::lhm_slot_type [2:0]              tx_slots_in,
    input  wire lhm_pkg::lhm_slot_type [2:0]              rx_slots_in,
    // counter values
    output logic [lhm_pkg::NUM_CTRS*lhm_pkg::CTR_WIDTH-1:0] counts_out
);
    import lhm_pkg::*;

    logic [63:0]          ctl_reg   [NUM_CTRS];
    logic [CTR_WIDTH-1:0] ctr_reg   [NUM_CTRS];
    logic                 ack_reg;
    logic [31:0]          rdata_reg;
    logic                 hit;
    logic                 take;
    logic [11:0]          ctl_rel;
    logic [11:0]          ctr_rel;
    logic                 ctl_sel;
    logic                 ctr_sel;
    logic [1:0]           reg_idx_ctl;
    logic [1:0]           reg_idx_ctr;
    logic                 hi_sel;
    logic [31:0]          rd_next;

    // one slot against one control value
    function automatic logic slot_match
    (
        input lhm_slot_type s,
        input logic [63:0]  c,
        input int           idx,
        input logic         is_rx
    );
        logic [2:0] slot_en;
        logic       ok;
        slot_en = c[SLOT_LSB +: 3];
        if (slot_en == 3'h0)
        begin
            slot_en = 3'h7;
        end
        ok = s.valid && slot_en[idx];
        if (c[EN_SRC_BIT])
        begin
            ok = ok && s.has_node_id && (s.src_node_id == c[SRC_LSB +: 4]);
        end
        if (c[EN_DST_BIT])
        begin
            ok = ok && (s.dst_node_id == c[DST_LSB +: 4]);
        end
        if (c[ISOCH_BIT])
        begin
            ok = ok && s.isoch;
        end
        if (c[SGL_BIT])
        begin
            ok = ok && s.single_slot;
        end
        if (c[DUAL_BIT])
        begin
            ok = ok && !s.single_slot;
        end
        if (c[NONDATA_BIT])
        begin
            ok = ok && !s.data_hdr;
        end
        if (c[DATA_BIT])
        begin
            ok = ok && s.data_hdr;
        end
        if (is_rx && c[REM_BIT])
        begin
            ok = ok && s.remote_target;
        end
        if (is_rx && c[LOC_BIT])
        begin
            ok = ok && !s.remote_target;
        end
        if (c[OPC_EN_BIT])
        begin
            ok = ok && (s.opcode == c[OPC_LSB +: 4])
                    && (s.msg_class == c[MC_LSB +: 4]);
            if (idx == NUM_SLOTS - 1)
            begin
                if (c[IMPLNULL_BIT])
                begin
                    ok = ok && s.implied_null;
                end
                if (c[NONZERO_BIT])
                begin
                    ok = ok && s.credit_nonzero;
                end
            end
        end
        return ok;
    endfunction

    // address decode
    always_comb
    begin
        hit         = (cfg.bus == CFG_BUS) && (cfg.dev == LINK_DEV)
                      && (cfg.func == CFG_FUNC);
        take        = cfg.req && !ack_reg && hit;
        ctl_rel     = cfg.offset - CTL_BASE;
        ctr_rel     = cfg.offset - CTR_BASE;
        ctl_sel     = (cfg.offset >= CTL_BASE) && (ctl_rel[11:3] < 9'(NUM_CTRS))
                      && (cfg.offset[1:0] == 2'h0);
        ctr_sel     = (cfg.offset >= CTR_BASE) && (ctr_rel[11:3] < 9'(NUM_CTRS))
                      && (cfg.offset[1:0] == 2'h0);
        reg_idx_ctl = ctl_rel[4:3];
        reg_idx_ctr = ctr_rel[4:3];
        hi_sel      = cfg.offset[2];
    end

    // read data mux, unmapped offsets read zero
    always_comb
    begin
        rd_next = 32'h0000_0000;
        if (ctl_sel)
        begin
            rd_next = hi_sel ? ctl_reg[reg_idx_ctl][63:32] : ctl_reg[reg_idx_ctl][31:0];
        end
        else if (ctr_sel)
        begin
            rd_next = hi_sel ? {16'h0000, ctr_reg[reg_idx_ctr][CTR_WIDTH-1:32]}
                             : ctr_reg[reg_idx_ctr][31:0];
        end
    end

    // answer one cycle after the request is taken
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= take;
            if (take)
            begin
                rdata_reg <= cfg.write ? 32'h0000_0000 : rd_next;
            end
        end
    end

    assign cfg.ack   = ack_reg;
    assign cfg.rdata = rdata_reg;

    // per-counter control and counting
    genvar g;
    generate
        for (g = 0; g < NUM_CTRS; g++)
        begin : gen_ctr
            logic [NUM_SLOTS-1:0] slot_hit;
            logic [1:0]           inc;
            logic                 is_tx;
            logic                 is_rx;

            always_comb
            begin
                is_tx = (ctl_reg[g][EV_LSB +: 8] == EV_TX_HDR_MATCH);
                is_rx = (ctl_reg[g][EV_LSB +: 8] == EV_RX_HDR_MATCH);
                for (int s = 0; s < NUM_SLOTS; s++)
                begin
                    slot_hit[s] = (is_tx && slot_match(tx_slots_in[s], ctl_reg[g], s, 1'b0))
                               || (is_rx && slot_match(rx_slots_in[s], ctl_reg[g], s, 1'b1));
                end
                inc = 2'(slot_hit[0]) + 2'(slot_hit[1]) + 2'(slot_hit[2]);
            end

            // control register with reserved bits held at zero
            always_ff @(posedge clock_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    ctl_reg[g] <= CTL_RESET;
                end
                else if (take && cfg.write && ctl_sel && (reg_idx_ctl == 2'(g)))
                begin
                    if (hi_sel)
                    begin
                        ctl_reg[g][63:32] <= cfg.wdata & CTL_WR_MASK[63:32];
                    end
                    else
                    begin
                        ctl_reg[g][31:0] <= cfg.wdata & CTL_WR_MASK[31:0];
                    end
                end
            end

            // 48-bit event counter, wraps
            always_ff @(posedge clock_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    ctr_reg[g] <= '0;
                end
                else if (ctl_reg[g][CNT_EN_BIT])
                begin
                    ctr_reg[g] <= ctr_reg[g] + CTR_WIDTH'(inc);
                end
            end

            assign counts_out[g*CTR_WIDTH +: CTR_WIDTH] = ctr_reg[g];
        end
    endgenerate

endmodule

`default_nettype wire

// File: rtl/lhm_pkg.sv
/*
 * Constants, field layout and types for the header-match counter filter
 * of one link layer, shared by the link end and the configuration end.
 * Assumes one clock for both ends and a configuration port in which one
 * request is outstanding at a time.
 */
// How it works
// - each control holds a resettable match extension
// - every counter keeps its own match settings
// - matching only for transmit/receive header events
// - slot select all clear means every slot
// - credit bits qualify third-slot opcode match only
// - source node enable compares 4-bit node ID
// - destination node enable compares 4-bit ID
// - software sets single or dual, not both
// - software sets data or non-data, not both
// - remote and local bits select received target
// - target bits: receive event only, one bit
// - opcode enable compares opcode from unit mask
// - registers at bus 3, function 0, devices 14-16
// - four 48-bit counters, each with own control
package lhm_pkg;

    // counters
    localparam int          NUM_CTRS         = 4;
    localparam int          CTR_WIDTH        = 48;
    localparam int          NUM_SLOTS        = 3;

    // configuration-space location
    localparam logic [7:0]  CFG_BUS          = 8'h03;
    localparam logic [2:0]  CFG_FUNC         = 3'h0;
    localparam logic [4:0]  CFG_DEV_LINK0    = 5'h0e;
    localparam logic [4:0]  CFG_DEV_LINK1    = 5'h0f;
    localparam logic [4:0]  CFG_DEV_LINK2    = 5'h10;

    // register offsets, each register is two dwords (low, high)
    localparam logic [11:0] CTR_BASE         = 12'h0a0;
    localparam logic [11:0] CTL_BASE         = 12'h0d8;
    localparam logic [11:0] REG_STRIDE       = 12'h008;
    localparam logic [11:0] HI_DWORD         = 12'h004;

    // control reset value and writable bits (63:56 and 44 reserved)
    localparam logic [63:0] CTL_RESET        = 64'h0000_0000_0000_0000;
    localparam logic [63:0] CTL_WR_MASK      = 64'h00ff_efff_ffff_ffff;

    // baseline control fields
    localparam int          EV_LSB           = 0;
    localparam int          MC_LSB           = 8;
    localparam int          OPC_LSB          = 12;
    localparam int          CNT_EN_BIT       = 22;

    // unit mask extension fields
    localparam int          UMX_LSB          = 32;
    localparam int          UMX_MSB          = 55;
    localparam int          IMPLNULL_BIT     = 55;
    localparam int          NONZERO_BIT      = 54;
    localparam int          SLOT_LSB         = 51;
    localparam int          EN_SRC_BIT       = 50;
    localparam int          SRC_LSB          = 46;
    localparam int          EN_DST_BIT       = 45;
    localparam int          DST_LSB          = 40;
    localparam int          ISOCH_BIT        = 39;
    localparam int          SGL_BIT          = 38;
    localparam int          DUAL_BIT         = 37;
    localparam int          NONDATA_BIT      = 36;
    localparam int          DATA_BIT         = 35;
    localparam int          REM_BIT          = 34;
    localparam int          LOC_BIT          = 33;
    localparam int          OPC_EN_BIT       = 32;

    // event selects
    localparam logic [7:0]  EV_TX_HDR_MATCH  = 8'h04;
    localparam logic [7:0]  EV_RX_HDR_MATCH  = 8'h05;

    // configuration end timeout
    localparam int          CFG_TIMEOUT_CYC  = 16;

    // one flit slot's header as seen by the filter
    typedef struct packed {
        logic       valid;
        logic [3:0] opcode;
        logic [3:0] msg_class;
        logic       has_node_id;
        logic [3:0] src_node_id;
        logic [3:0] dst_node_id;
        logic       single_slot;
        logic       data_hdr;
        logic       remote_target;
        logic       isoch;
        logic       implied_null;
        logic       credit_nonzero;
    } lhm_slot_type;

endpackage

// File: rtl/lhm_cfg_if.sv
/*
 * Configuration-space access port between the configuration end and the
 * link end. Assumes the requester holds a request until it sees ack.
 */
`timescale 1ns/1ps
`default_nettype none

interface lhm_cfg_if;
    logic        req;
    logic        write;
    logic [7:0]  bus;
    logic [4:0]  dev;
    logic [2:0]  func;
    logic [11:0] offset;
    logic [31:0] wdata;
    logic        ack;
    logic [31:0] rdata;

    modport link_end
    (
        input  req,
        input  write,
        input  bus,
        input  dev,
        input  func,
        input  offset,
        input  wdata,
        output ack,
        output rdata
    );

    modport config_end
    (
        output req,
        output write,
        output bus,
        output dev,
        output func,
        output offset,
        output wdata,
        input  ack,
        input  rdata
    );
endinterface

`default_nettype wire

// File: rtl/lhm_config_end.sv
/*
 * Configuration end: issues dword reads and writes to the link end's
 * registers and refuses control writes with conflicting match bits.
 * Assumes the user programs a counter's event select before its
 * target bits.
 */
`timescale 1ns/1ps
`default_nettype none

module lhm_config_end
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    // configuration access
    lhm_cfg_if.config_end    cfg,
    // user commands
    input  wire logic        cmd_valid_in,
    input  wire logic        cmd_write_in,
    input  wire logic [4:0]  cmd_dev_in,
    input  wire logic [11:0] cmd_offset_in,
    input  wire logic [31:0] cmd_wdata_in,
    output logic             cmd_ready_out,
    // user responses
    output logic             rsp_valid_out,
    output logic             rsp_error_out,
    output logic [31:0]      rsp_data_out
);
    import lhm_pkg::*;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_RESP = 3'b100
    } lhm_state_type;

    lhm_state_type state_reg;
    lhm_state_type state_next;
    logic [7:0]    ev_shadow_reg [NUM_CTRS];
    logic [4:0]    wait_reg;
    logic          req_reg;
    logic          write_reg;
    logic [4:0]    dev_reg;
    logic [11:0]   offset_reg;
    logic [31:0]   wdata_reg;
    logic          rsp_valid_reg;
    logic          rsp_error_reg;
    logic [31:0]   rsp_data_reg;
    logic [11:0]   rel;
    logic          ctl_hit;
    logic [1:0]    idx;
    logic          illegal;
    logic          accept;
    logic          timeout;

    // check control high-dword writes before issuing them
    always_comb
    begin
        rel     = cmd_offset_in - CTL_BASE;
        ctl_hit = (cmd_offset_in >= CTL_BASE) && (rel[11:3] < 9'(NUM_CTRS))
                  && (cmd_offset_in[1:0] == 2'h0);
        idx     = rel[4:3];
        illegal = 1'b0;
        if (cmd_write_in && ctl_hit && cmd_offset_in[2])
        begin
            illegal = (cmd_wdata_in[SGL_BIT-32] && cmd_wdata_in[DUAL_BIT-32])
                   || (cmd_wdata_in[NONDATA_BIT-32] && cmd_wdata_in[DATA_BIT-32])
                   || (cmd_wdata_in[REM_BIT-32] && cmd_wdata_in[LOC_BIT-32])
                   || ((cmd_wdata_in[REM_BIT-32] || cmd_wdata_in[LOC_BIT-32])
                       && (ev_shadow_reg[idx] != EV_RX_HDR_MATCH));
        end
        accept  = cmd_valid_in && (state_reg == ST_IDLE);
        timeout = (wait_reg == 5'(CFG_TIMEOUT_CYC - 1));
    end

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (accept)
                begin
                    state_next = illegal ? ST_RESP : ST_BUSY;
                end
            end
            ST_BUSY:
            begin
                if (cfg.ack || timeout)
                begin
                    state_next = ST_RESP;
                end
            end
            ST_RESP:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // request held until ack or timeout
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            req_reg    <= 1'b0;
            write_reg  <= 1'b0;
            dev_reg    <= 5'h00;
            offset_reg <= 12'h000;
            wdata_reg  <= 32'h0000_0000;
            wait_reg   <= 5'h00;
        end
        else if (accept && !illegal)
        begin
            req_reg    <= 1'b1;
            write_reg  <= cmd_write_in;
            dev_reg    <= cmd_dev_in;
            offset_reg <= cmd_offset_in;
            wdata_reg  <= cmd_wdata_in;
            wait_reg   <= 5'h00;
        end
        else if (state_reg == ST_BUSY)
        begin
            wait_reg <= wait_reg + 5'h01;
            if (cfg.ack || timeout)
            begin
                req_reg <= 1'b0;
            end
        end
    end

    // event select shadow for the target-bit check
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            for (int i = 0; i < NUM_CTRS; i++)
            begin
                ev_shadow_reg[i] <= 8'h00;
            end
        end
        else if (accept && !illegal && cmd_write_in && ctl_hit && !cmd_offset_in[2])
        begin
            ev_shadow_reg[idx] <= cmd_wdata_in[EV_LSB +: 8];
        end
    end

    // one-cycle response
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rsp_valid_reg <= 1'b0;
            rsp_error_reg <= 1'b0;
            rsp_data_reg  <= 32'h0000_0000;
        end
        else
        begin
            rsp_valid_reg <= 1'b0;
            if (accept && illegal)
            begin
                rsp_valid_reg <= 1'b1;
                rsp_error_reg <= 1'b1;
                rsp_data_reg  <= 32'h0000_0000;
            end
            else if ((state_reg == ST_BUSY) && (cfg.ack || timeout))
            begin
                rsp_valid_reg <= 1'b1;
                rsp_error_reg <= !cfg.ack;
                rsp_data_reg  <= cfg.ack ? cfg.rdata : 32'h0000_0000;
            end
        end
    end

    assign cfg.req       = req_reg;
    assign cfg.write     = write_reg;
    assign cfg.bus       = CFG_BUS;
    assign cfg.dev       = dev_reg;
    assign cfg.func      = CFG_FUNC;
    assign cfg.offset    = offset_reg;
    assign cfg.wdata     = wdata_reg;
    assign cmd_ready_out = (state_reg == ST_IDLE);
    assign rsp_valid_out = rsp_valid_reg;
    assign rsp_error_out = rsp_error_reg;
    assign rsp_data_out  = rsp_data_reg;

endmodule

`default_nettype wire

// File: verif/lhm_asserts.sv
/*
 * Concurrent checks on the configuration port between the two ends.
 * Assumes one clock and a link end answering at LINK_DEV.
 */
`timescale 1ns/1ps
`default_nettype none

module lhm_asserts
#(
    parameter logic [4:0] LINK_DEV = 5'h0e
)
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    // configuration port
    input  wire logic        req,
    input  wire logic        write,
    input  wire logic [7:0]  bus,
    input  wire logic [4:0]  dev,
    input  wire logic [2:0]  func,
    input  wire logic [11:0] offset,
    input  wire logic [31:0] wdata,
    input  wire logic        ack,
    input  wire logic [31:0] rdata
);
    logic [11:0] off_reg;
    logic        wr_reg;
    logic        hit;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    assign hit = req && !ack && dev == LINK_DEV && bus == 8'h03 && func == 3'h0;

    // request qualifiers as seen at the taking edge
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            off_reg <= 12'h000;
            wr_reg  <= 1'b0;
        end
        else
        begin
            off_reg <= offset;
            wr_reg  <= write;
        end
    end

    a_ack_when_taken: assert property (hit |=> ack)
        else $error("ack missing after request");
    a_no_stray_ack: assert property (ack |-> $past(hit))
        else $error("ack without matching request");
    a_ack_single_pulse: assert property (ack |=> !ack && !req)
        else $error("ack or request held too long");
    a_req_held: assert property (req && !ack |=>
        !req || ($stable(offset) && $stable(wdata) && $stable(write)))
        else $error("request changed while pending");
    a_bus_func_fixed: assert property (bus == 8'h03 && func == 3'h0)
        else $error("bus or function wrong");
    a_write_reads_zero: assert property (ack && wr_reg |-> rdata == 32'h0)
        else $error("write returned data");
    a_ctl_rsv_zero: assert property (ack && !wr_reg &&
        off_reg inside {12'h0dc, 12'h0e4, 12'h0ec, 12'h0f4}
        |-> rdata[31:24] == 8'h00 && !rdata[12])
        else $error("reserved control bits read set");
    a_ctr_hi_zero: assert property (ack && !wr_reg &&
        off_reg inside {12'h0a4, 12'h0ac, 12'h0b4, 12'h0bc} |-> rdata[31:16] == 16'h0)
        else $error("counter upper bits read set");
    a_no_conflict_sent: assert property (req && write &&
        offset inside {12'h0dc, 12'h0e4, 12'h0ec, 12'h0f4} |->
        !(wdata[6] && wdata[5]) && !(wdata[4] && wdata[3]) && !(wdata[2] && wdata[1]))
        else $error("conflicting match bits sent");

    c_write: cover property (hit && write);
    c_read: cover property (hit && !write);
    c_other_dev: cover property (req && dev != LINK_DEV);
endmodule

`default_nettype wire

// File: verif/testbench.sv
/*
 * Self-checking bench joining the configuration end to the link end.
 * Assumes both ends on one 250 MHz clock and link end at device 14.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import lhm_pkg::*;
    typedef struct packed
    {
        logic [31:0] lo;
        logic [31:0] hi;
        logic [1:0]  n;
    } lhm_row_type;
    // control low, control high, matching slots per cycle
    localparam lhm_row_type ROWS [20] = '{
        '{32'h00400004, 32'h00000000, 2'd3}, '{32'h00400005, 32'h00000000, 2'd3},
        '{32'h00400002, 32'h00000000, 2'd0}, '{32'h00400004, 32'h00200000, 2'd1},
        '{32'h00400004, 32'h00380000, 2'd3}, '{32'h00400004, 32'h00054000, 2'd3},
        '{32'h00400004, 32'h00058000, 2'd0}, '{32'h00400004, 32'h00002900, 2'd3},
        '{32'h00400004, 32'h00002800, 2'd0}, '{32'h00403204, 32'h00000001, 2'd3},
        '{32'h00404204, 32'h00000001, 2'd0}, '{32'h00403204, 32'h00400001, 2'd2},
        '{32'h00400005, 32'h00000004, 2'd3}, '{32'h00400005, 32'h00000002, 2'd0},
        '{32'h00400004, 32'h00000040, 2'd3}, '{32'h00400004, 32'h00000020, 2'd0},
        '{32'h00400004, 32'h00000008, 2'd0}, '{32'h00400004, 32'h00000010, 2'd3},
        '{32'h00403204, 32'h00800001, 2'd2}, '{32'h00400004, 32'h00000080, 2'd0}};
    localparam lhm_slot_type HDR = '{1'b1, 4'h3, 4'h2, 1'b1, 4'h5, 4'h9,
                                     1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    localparam logic [31:0] BAD [4] = '{32'h60, 32'h18, 32'h06, 32'h04};

    logic               clock_in, nrst_in, cmd_valid, cmd_write;
    logic               cmd_ready, rsp_valid, rsp_error, er;
    logic [4:0]         cmd_dev;
    logic [11:0]        cmd_off;
    logic [31:0]        cmd_wdata, rsp_data, rd;
    lhm_slot_type [2:0] tx_slots, rx_slots;
    logic [191:0]       counts;
    logic [47:0]        base;
    int                 err_count, total_checks;
    int                 cycles = 0;

    lhm_cfg_if u_lhm_cfg_if ();
    lhm_link_end #(.LINK_DEV(CFG_DEV_LINK0)) u_lhm_link_end (.clock_in(clock_in),
        .nrst_in(nrst_in), .cfg(u_lhm_cfg_if.link_end), .tx_slots_in(tx_slots),
        .rx_slots_in(rx_slots), .counts_out(counts));
    lhm_config_end u_lhm_config_end (.clock_in(clock_in), .nrst_in(nrst_in),
        .cfg(u_lhm_cfg_if.config_end), .cmd_valid_in(cmd_valid), .cmd_write_in(cmd_write),
        .cmd_dev_in(cmd_dev), .cmd_offset_in(cmd_off), .cmd_wdata_in(cmd_wdata),
        .cmd_ready_out(cmd_ready), .rsp_valid_out(rsp_valid), .rsp_error_out(rsp_error),
        .rsp_data_out(rsp_data));
    lhm_asserts #(.LINK_DEV(CFG_DEV_LINK0)) u_lhm_asserts (.clock_in(clock_in),
        .nrst_in(nrst_in), .req(u_lhm_cfg_if.req), .write(u_lhm_cfg_if.write),
        .bus(u_lhm_cfg_if.bus), .dev(u_lhm_cfg_if.dev), .func(u_lhm_cfg_if.func),
        .offset(u_lhm_cfg_if.offset), .wdata(u_lhm_cfg_if.wdata),
        .ack(u_lhm_cfg_if.ack), .rdata(u_lhm_cfg_if.rdata));

    task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        chk_val({47'h0, got}, {47'h0, exp});
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one dword command, waits for the response pulse
    task automatic cfg(input logic w, input logic [4:0] d, input logic [11:0] o,
                       input logic [31:0] wd);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1)
            @(negedge clock_in);
        @(posedge clock_in);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_dev   <= d;
        cmd_off   <= o;
        cmd_wdata <= wd;
        @(posedge clock_in);
        cmd_valid <= 1'b0;
        while (rsp_valid !== 1'b1 && n < 40)
        begin
            @(negedge clock_in);
            n++;
        end
        if (n == 40)
        begin
            err_count++;
            $display("wrong value at %0t: no response", $time);
        end
        rd = rsp_data;
        er = rsp_error;
    endtask

    // same header in every slot of both paths for four cycles
    task automatic run(input int g, input logic [1:0] n);
        @(negedge clock_in);
        base = counts[g*48 +: 48];
        @(posedge clock_in);
        tx_slots <= {3{HDR}};
        rx_slots <= {3{HDR}};
        repeat (4) @(posedge clock_in);
        tx_slots <= '0;
        rx_slots <= '0;
        repeat (2) @(posedge clock_in);
        @(negedge clock_in);
        chk_val(counts[g*48 +: 48] - base, 48'(4 * n));
    endtask

    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    // cuts a hang short
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            err_count++;
            $display("wrong value at %0t: run timed out", $time);
            close_out();
        end
    end

    initial
    begin
        nrst_in = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_dev = 5'h00;
        cmd_off = 12'h000;
        cmd_wdata = 32'h0;
        tx_slots = '0;
        rx_slots = '0;
        err_count = 0;
        total_checks = 0;
        repeat (4) @(posedge clock_in);
        nrst_in <= 1'b1;
        foreach (ROWS[i])
        begin
            cfg(1'b1, CFG_DEV_LINK0, CTL_BASE + 12'(8 * (i % 4)), ROWS[i].lo);
            cfg(1'b1, CFG_DEV_LINK0, CTL_BASE + HI_DWORD + 12'(8 * (i % 4)), ROWS[i].hi);
            chk_flag(er, 1'b0);
            run(i % 4, ROWS[i].n);
            $display("row %0d done", i);
        end
        cfg(1'b1, CFG_DEV_LINK0, CTL_BASE + 12'h008, 32'h00000004);
        foreach (BAD[i])
        begin
            cfg(1'b1, CFG_DEV_LINK0, CTL_BASE + 12'h00c, BAD[i]);
            chk_flag(er, 1'b1);
        end
        $display("refusal test done");
        cfg(1'b1, CFG_DEV_LINK0, CTL_BASE + 12'h008, 32'h00000005);
        cfg(1'b1, CFG_DEV_LINK0, CTL_BASE + 12'h00c, 32'hffffffab);
        cfg(1'b0, CFG_DEV_LINK0, CTL_BASE + 12'h00c, 32'h0);
        chk_val({16'h0, rd}, 48'h00ffefab);
        cfg(1'b0, CFG_DEV_LINK1, CTL_BASE, 32'h0);
        chk_flag(er, 1'b1);
        cfg(1'b0, CFG_DEV_LINK0, 12'h300, 32'h0);
        chk_val({16'h0, rd}, 48'h0);
        $display("register test done");
        @(posedge clock_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        nrst_in <= 1'b1;
        cfg(1'b0, CFG_DEV_LINK0, CTL_BASE + 12'h00c, 32'h0);
        chk_val({16'h0, rd}, 48'h0);
        for (int g = 0; g < 4; g++)
            chk_val(counts[g*48 +: 48], 48'h0);
        cfg(1'b1, CFG_DEV_LINK0, CTL_BASE, 32'h00400004);
        run(0, 2'd3);
        cfg(1'b0, CFG_DEV_LINK0, CTR_BASE, 32'h0);
        chk_val({16'h0, rd}, 48'd12);
        cfg(1'b0, CFG_DEV_LINK0, CTR_BASE + HI_DWORD, 32'h0);
        chk_val({16'h0, rd}, 48'h0);
        $display("reset and counter test done");
        close_out();
    end
endmodule

`default_nettype wire
